// ### sbsc_array_model.sv
/*
  Behavioural memory array behind the command queue of the cycle control.
  Assumes commands arrive from registers on sys_clk; stall comes from the bench.
*/
`timescale 1ns/10ps
`include "sbsc_consts.svh"

module sbsc_array_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic stall,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire sbsc_pkg::sbsc_cmd_t cmd,
  output logic rd_valid,
  output logic [`SBSC_DATA_W-1:0] rd_data
);
  logic [`SBSC_DATA_W-1:0] mem [int];
  logic [`SBSC_DATA_W-1:0] word;

  // Stall lets the bench fill the queue until it refuses
  assign cmd_ready = !stall;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
      rd_data <= '0;
    end else begin
      rd_valid <= 1'b0;
      rd_data <= ~rd_data; // Stale data never looks valid
      if (cmd_valid && cmd_ready) begin
        word = mem.exists(cmd.addr) ? mem[cmd.addr] : '0;
        if (cmd.write) begin
          for (int i = 0; i < `SBSC_LANES; i++) begin
            if (!cmd.lane_n[i]) word[8*i +: 8] = cmd.data[8*i +: 8];
          end
          mem[cmd.addr] = word;
        end else begin
          rd_valid <= 1'b1;
          rd_data <= word;
        end
      end
    end
  end
endmodule : sbsc_array_model

// ### sbsc_consts.svh
/*
  Constants of the burst SRAM cycle control: widths, burst order
  encoding, sleep timing and queue depth.
  Assumes inclusion by bare name, before any user of the macros.
*/
`ifndef SBSC_CONSTS_SVH
`define SBSC_CONSTS_SVH

// ---------------------------------------------------------------
// Widths
// ---------------------------------------------------------------
`define SBSC_ADDR_W 20
`define SBSC_DATA_W 32
`define SBSC_LANES 4
`define SBSC_BURST_W 2

// ---------------------------------------------------------------
// Burst order pin level, sleep timing in clock cycles and queue depth
// ---------------------------------------------------------------
`define SBSC_ORDER_LINEAR 1'b0
`define SBSC_SLEEP_ENTRY_CYC 2
`define SBSC_SLEEP_EXIT_CYC 2
`define SBSC_FIFO_DEPTH 32

`endif

// ### sbsc_cycle_ctrl.sv
/*
  Cycle control of a synchronous flow-through burst SRAM: cycle
  decode, two-bit burst counter, sleep sequencing, data pin enable,
  and a command queue toward the memory array.
  Assumes bus inputs are synchronous to sys_clk; sleep_request and
  output_enable_n are asynchronous pins.
*/
// What this block does
// - Burst order pin high: low address bits are start XOR beat count
// - Burst order pin low: low address bits count up modulo four
// - Sleep request is asynchronous and puts the device to sleep
// - Sleep entry and sleep exit each take two clock cycles
// - Stored contents stay untouched while asleep
// - Accesses in flight at sleep entry are dropped
// - Deselect cycle with data pins off on bad selects
// - Processor strobe with selects active begins a read unless the queue is full
// - Controller strobe begins write or read from composite write
// - Advance low steps the burst address and accesses it
// - Advance high holds the burst address and repeats the access
// - Continue and suspend choose read or write every clock
// - Composite write: global write, or byte write with a lane
// - Writes only within a burst that either strobe started, or on controller start
// - Output enable acts unclocked and is masked during writes
// - Read drives data pins only while output enable is low
// - Sleep request tri-states the data pins at once
// - Burst counter loads from the two low address bits at start
// - Controller strobe is ignored while processor strobe is low with the first select low
// - Global write writes every byte lane
`timescale 1ns/10ps
`include "sbsc_consts.svh"

module sbsc_cycle_ctrl #(
  parameter int ADDR_W = `SBSC_ADDR_W,
  parameter int DEPTH = `SBSC_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic burst_order,
  input wire logic sleep_request,
  input wire logic chip_select_first_n,
  input wire logic chip_select_second,
  input wire logic chip_select_third_n,
  input wire logic processor_addr_strobe_n,
  input wire logic controller_addr_strobe_n,
  input wire logic burst_advance_n,
  input wire logic global_write_n,
  input wire logic byte_write_enable_n,
  input wire logic [`SBSC_LANES-1:0] byte_lane_select_n,
  input wire logic output_enable_n,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [`SBSC_DATA_W-1:0] dq_in,
  output logic [`SBSC_DATA_W-1:0] dq_out,
  output logic dq_oe,
  output logic arr_cmd_valid,
  input wire logic arr_cmd_ready,
  output sbsc_pkg::sbsc_cmd_t arr_cmd,
  input wire logic arr_rd_valid,
  input wire logic [`SBSC_DATA_W-1:0] arr_rd_data,
  output sbsc_pkg::sbsc_cycle_t cycle_kind,
  output logic [ADDR_W-1:0] burst_addr,
  output logic sleeping,
  output logic cmd_accept_ready
);

  // -------------------------------------------------------------
  // Burst address order
  // -------------------------------------------------------------
  // XOR or sum per beat
  function automatic logic [1:0] beat_addr(input logic [1:0] base,
                                           input logic [1:0] beat,
                                           input logic linear);
    if (linear) begin
      beat_addr = 2'(base + beat);
    end else begin
      beat_addr = base ^ beat;
    end
  endfunction : beat_addr

  // -------------------------------------------------------------
  // Declarations
  // -------------------------------------------------------------
  logic sleep_meta;
  logic sleep_sync;
  sbsc_pkg::sbsc_sleep_t sst;
  logic [1:0] sleep_timer;
  logic burst_live;
  logic linear_q;
  logic [1:0] base;
  logic [1:0] cnt;
  logic [ADDR_W-3:0] hi;
  logic read_phase;
  logic wr_comp;
  logic ce_ok;
  logic start_p;
  logic start_c;
  logic desel;
  logic q_ready;
  logic cmd_push;
  sbsc_pkg::sbsc_cycle_t cur;
  sbsc_pkg::sbsc_cmd_t cmd_in;

  // -------------------------------------------------------------
  // Input decode
  // -------------------------------------------------------------
  // composite write level
  assign wr_comp = !global_write_n || (!byte_write_enable_n && !(&byte_lane_select_n));
  assign ce_ok = chip_select_second && !chip_select_third_n;
  // Processor strobe counts only with the first select low
  assign start_p = !processor_addr_strobe_n && !chip_select_first_n;
  // controller strobe masked by a counted processor strobe
  assign start_c = !controller_addr_strobe_n && !start_p;
  // bad selects on a strobe start
  assign desel = (start_p && !ce_ok) || (start_c && (chip_select_first_n || !ce_ok));

  // Cycle kind; a full queue turns the cycle into idle and its access is lost
  always_comb begin
    if (sst != sbsc_pkg::SBSC_AWAKE) begin
      cur = sbsc_pkg::SBSC_SLEEP;
    end else if (desel) begin
      cur = sbsc_pkg::SBSC_DESEL;
    end else if (!q_ready) begin
      cur = sbsc_pkg::SBSC_IDLE;
    end else if (start_p) begin
      // processor start is always a read
      cur = sbsc_pkg::SBSC_BEGIN_RD;
    end else if (start_c) begin
      cur = wr_comp ? sbsc_pkg::SBSC_BEGIN_WR : sbsc_pkg::SBSC_BEGIN_RD;
    end else if (!burst_live) begin
      cur = sbsc_pkg::SBSC_IDLE;
    end else if (!burst_advance_n) begin
      cur = sbsc_pkg::SBSC_CONT;
    end else begin
      cur = sbsc_pkg::SBSC_SUSP;
    end
  end

  // -------------------------------------------------------------
  // Command to the array
  // -------------------------------------------------------------
  // Access address and data for the cycle being decoded
  always_comb begin
    cmd_in.data = dq_in;
    cmd_in.lane_n = !global_write_n ? '0 : byte_lane_select_n;
    cmd_in.write = 1'b0;
    cmd_in.addr = {hi, beat_addr(base, cnt, linear_q)};
    cmd_push = 1'b0;
    case (cur)
      sbsc_pkg::SBSC_BEGIN_RD, sbsc_pkg::SBSC_BEGIN_WR: begin
        cmd_push = 1'b1;
        cmd_in.addr = addr_in;
        // only controller starts write in their first cycle
        cmd_in.write = (cur == sbsc_pkg::SBSC_BEGIN_WR);
      end
      sbsc_pkg::SBSC_CONT: begin
        cmd_push = 1'b1;
        cmd_in.addr = {hi, beat_addr(base, 2'(cnt + 2'h1), linear_q)};
        cmd_in.write = wr_comp;
      end
      sbsc_pkg::SBSC_SUSP: begin
        cmd_push = 1'b1;
        cmd_in.write = wr_comp;
      end
      default: begin
        // no array access while asleep or deselected
        cmd_push = 1'b0;
      end
    endcase
  end

  sbsc_fifo #(.WIDTH($bits(sbsc_pkg::sbsc_cmd_t)), .DEPTH(DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(cmd_push),
    .in_ready(q_ready),
    .in_data(cmd_in),
    .out_valid(arr_cmd_valid),
    .out_ready(arr_cmd_ready),
    .out_data(arr_cmd)
  );

  // -------------------------------------------------------------
  // Sleep sequencing
  // -------------------------------------------------------------
  // two-flop synchroniser on the asynchronous request
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_meta <= 1'b0;
      sleep_sync <= 1'b0;
    end else begin
      sleep_meta <= sleep_request;
      sleep_sync <= sleep_meta;
    end
  end

  // entry and exit each run their full two cycles
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sst <= sbsc_pkg::SBSC_AWAKE;
      sleep_timer <= 2'h0;
    end else begin
      case (sst)
        sbsc_pkg::SBSC_AWAKE: begin
          if (sleep_sync) begin
            sst <= sbsc_pkg::SBSC_ENTERING;
            sleep_timer <= 2'(`SBSC_SLEEP_ENTRY_CYC - 1);
          end
        end
        sbsc_pkg::SBSC_ENTERING: begin
          if (sleep_timer == 2'h0) begin
            sst <= sbsc_pkg::SBSC_ASLEEP;
          end else begin
            sleep_timer <= 2'(sleep_timer - 2'h1);
          end
        end
        sbsc_pkg::SBSC_ASLEEP: begin
          if (!sleep_sync) begin
            sst <= sbsc_pkg::SBSC_EXITING;
            sleep_timer <= 2'(`SBSC_SLEEP_EXIT_CYC - 1);
          end
        end
        default: begin
          if (sleep_timer == 2'h0) begin
            sst <= sbsc_pkg::SBSC_AWAKE;
          end else begin
            sleep_timer <= 2'(sleep_timer - 2'h1);
          end
        end
      endcase
    end
  end

  // -------------------------------------------------------------
  // Burst state
  // -------------------------------------------------------------
  // counter loads the low address bits; wraps modulo four
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      burst_live <= 1'b0;
      linear_q <= 1'b0;
      base <= 2'h0;
      cnt <= 2'h0;
      hi <= '0;
    end else begin
      case (cur)
        sbsc_pkg::SBSC_BEGIN_RD, sbsc_pkg::SBSC_BEGIN_WR: begin
          burst_live <= 1'b1;
          linear_q <= (burst_order == `SBSC_ORDER_LINEAR);
          base <= addr_in[1:0];
          cnt <= 2'h0;
          hi <= addr_in[ADDR_W-1:2];
        end
        sbsc_pkg::SBSC_CONT: begin
          cnt <= 2'(cnt + 2'h1);
        end
        // sleep and deselect drop the burst
        sbsc_pkg::SBSC_SLEEP, sbsc_pkg::SBSC_DESEL: begin
          burst_live <= 1'b0;
        end
        default: begin
          burst_live <= burst_live;
        end
      endcase
    end
  end

  // -------------------------------------------------------------
  // Observed state and data path
  // -------------------------------------------------------------
  // Outputs mirror the decoded cycle one clock later
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cycle_kind <= sbsc_pkg::SBSC_IDLE;
      burst_addr <= '0;
      sleeping <= 1'b0;
      cmd_accept_ready <= 1'b1;
      read_phase <= 1'b0;
      dq_out <= '0;
    end else begin
      cycle_kind <= cur;
      burst_addr <= cmd_in.addr;
      sleeping <= (sst != sbsc_pkg::SBSC_AWAKE);
      cmd_accept_ready <= q_ready;
      // write cycles mask the output drivers
      read_phase <= cmd_push && !cmd_in.write;
      if (arr_rd_valid) begin
        dq_out <= arr_rd_data;
      end
    end
  end

  // Pin enable stays unclocked so output enable and sleep act at once
  // drive only on a read with output enable low; sleep off
  assign dq_oe = read_phase && !output_enable_n && !sleep_request;

  // -------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------
  property p_interleave;
    @(posedge sys_clk) disable iff (!rst_n)
      (cur == sbsc_pkg::SBSC_CONT && !linear_q) |-> cmd_in.addr[1:0] == (base ^ 2'(cnt + 2'h1));
  endproperty
  a_interleave: assert property (p_interleave) else $error("interleave order wrong");

  property p_linear;
    @(posedge sys_clk) disable iff (!rst_n)
      (cur == sbsc_pkg::SBSC_CONT && linear_q) |-> cmd_in.addr[1:0] == 2'(base + cnt + 2'h1);
  endproperty
  a_linear: assert property (p_linear) else $error("linear order wrong");

  property p_entry;
    @(posedge sys_clk) disable iff (!rst_n)
      (sst == sbsc_pkg::SBSC_AWAKE && sleep_sync) |=>
        (sst == sbsc_pkg::SBSC_ENTERING) [*2] ##1 (sst == sbsc_pkg::SBSC_ASLEEP);
  endproperty
  a_entry: assert property (p_entry) else $error("sleep entry timing wrong");

  property p_exit;
    @(posedge sys_clk) disable iff (!rst_n)
      (sst == sbsc_pkg::SBSC_ASLEEP && !sleep_sync) |=>
        (sst == sbsc_pkg::SBSC_EXITING) [*2] ##1 (sst == sbsc_pkg::SBSC_AWAKE);
  endproperty
  a_exit: assert property (p_exit) else $error("sleep exit timing wrong");

  property p_no_access_asleep;
    @(posedge sys_clk) disable iff (!rst_n)
      sleeping |-> !$past(cmd_push);
  endproperty
  a_no_access_asleep: assert property (p_no_access_asleep) else $error("access in sleep");

  property p_abort;
    @(posedge sys_clk) disable iff (!rst_n)
      (sst == sbsc_pkg::SBSC_ENTERING) |=> !burst_live;
  endproperty
  a_abort: assert property (p_abort) else $error("burst survived sleep");

  property p_desel;
    @(posedge sys_clk) disable iff (!rst_n)
      (sst == sbsc_pkg::SBSC_AWAKE && desel) |=> !read_phase && !dq_oe && !burst_live;
  endproperty
  a_desel: assert property (p_desel) else $error("deselect not honoured");

  property p_processor_addr_strobe_n_read;
    @(posedge sys_clk) disable iff (!rst_n)
      (sst == sbsc_pkg::SBSC_AWAKE && start_p && ce_ok && q_ready) |->
        cmd_push && !cmd_in.write && cmd_in.addr == addr_in;
  endproperty
  a_processor_addr_strobe_n_read: assert property (p_processor_addr_strobe_n_read) else $error("processor start not read");

  property p_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      (cur == sbsc_pkg::SBSC_SUSP) |=> $stable(cnt) && burst_addr[1:0] == beat_addr(base, cnt, linear_q);
  endproperty
  a_hold: assert property (p_hold) else $error("suspend moved address");

  property p_write_origin;
    @(posedge sys_clk) disable iff (!rst_n)
      (cmd_push && cmd_in.write) |-> burst_live || start_c;
  endproperty
  a_write_origin: assert property (p_write_origin) else $error("write without burst");

  property p_all_lanes;
    @(posedge sys_clk) disable iff (!rst_n)
      (cmd_push && !global_write_n) |-> cmd_in.lane_n == '0;
  endproperty
  a_all_lanes: assert property (p_all_lanes) else $error("global write lanes");

  c_burst4: cover property (@(posedge sys_clk) disable iff (!rst_n)
    (cur == sbsc_pkg::SBSC_BEGIN_WR) ##1 (cur == sbsc_pkg::SBSC_CONT) [*3]);
  c_sleep: cover property (@(posedge sys_clk) disable iff (!rst_n)
    (sst == sbsc_pkg::SBSC_EXITING) ##2 (sst == sbsc_pkg::SBSC_AWAKE));
  c_full: cover property (@(posedge sys_clk) disable iff (!rst_n) !q_ready);

endmodule : sbsc_cycle_ctrl

// ### sbsc_fifo.sv
/*
  First-word-fall-through queue with valid and ready on both sides.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/10ps

module sbsc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW-1:0] next_rd_ptr;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign next_rd_ptr = pop ? PW'(rd_ptr + 1'b1) : rd_ptr;

  // Occupancy; pushes and pops may share a cycle
  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = CW'(count + 1'b1);
    end else if (pop && !push) begin
      next_count = CW'(count - 1'b1);
    end
  end

  // Pointers, count and registered flags
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= PW'(wr_ptr + 1'b1);
      end
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      in_ready <= (next_count != CW'(DEPTH));
      // A word written to the slot being read shows one cycle later
      out_valid <= (next_count != '0) && !(push && (wr_ptr == next_rd_ptr));
    end
  end

  sbsc_ram #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_ram (
    .sys_clk(sys_clk),
    .wr_en(push),
    .wr_addr(wr_ptr),
    .wr_data(in_data),
    .rd_addr(next_rd_ptr),
    .rd_data(out_data)
  );

endmodule : sbsc_fifo

// ### sbsc_pkg.sv
/*
  Types of the burst SRAM cycle control: cycle kinds, sleep states
  and the command word passed toward the memory array.
  Assumes sbsc_consts.svh is on the include path.
*/
`include "sbsc_consts.svh"

package sbsc_pkg;

  // Cycle kind decoded on each clock
  typedef enum logic [2:0] {
    SBSC_DESEL = 3'h0,
    SBSC_BEGIN_RD = 3'h1,
    SBSC_BEGIN_WR = 3'h3,
    SBSC_CONT = 3'h2,
    SBSC_SUSP = 3'h6,
    SBSC_IDLE = 3'h7,
    SBSC_SLEEP = 3'h5
  } sbsc_cycle_t;

  // Sleep sequencer, Gray coded around the loop
  typedef enum logic [1:0] {
    SBSC_AWAKE = 2'h0,
    SBSC_ENTERING = 2'h1,
    SBSC_ASLEEP = 2'h3,
    SBSC_EXITING = 2'h2
  } sbsc_sleep_t;

  // One access handed to the array
  typedef struct packed {
    logic [`SBSC_ADDR_W-1:0] addr;
    logic write;
    logic [`SBSC_LANES-1:0] lane_n;
    logic [`SBSC_DATA_W-1:0] data;
  } sbsc_cmd_t;

endpackage : sbsc_pkg

// ### sbsc_ram.sv
/*
  Simple dual-port storage for the command queue, registered read.
  Assumes one clock; no reset on the array itself.
*/
`timescale 1ns/10ps

module sbsc_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Write port
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read port, old data on a same-address collision
  always_ff @(posedge sys_clk) begin
    rd_data <= mem[rd_addr];
  end

endmodule : sbsc_ram

// ### tb.sv
/*
  Self-checking bench of the burst SRAM cycle control with an array model.
  Assumes the design and model files are compiled before it.
*/
`timescale 1ns/10ps
`include "sbsc_consts.svh"

module tb;
  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  // Control word {sel1_n, pstb_n, cstb_n, step_n, glw_n, bwr_n}
  localparam logic [5:0] IDL = 6'h37, PST = 6'h05, CSG = 6'h15, CSB = 6'h16;
  localparam logic [5:0] CNT = 6'h3b, CNW = 6'h39, SUR = 6'h3f, SUB = 6'h3e;
  localparam logic [19:0] A2 = 20'h29696;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic order = 1'b1;
  logic sleep = 1'b0;
  logic sel1_n = 1'b1;
  logic sel2 = 1'b1;
  logic sel3_n = 1'b0;
  logic pstb_n = 1'b1;
  logic cstb_n = 1'b0;
  logic step_n = 1'b1;
  logic glw_n = 1'b1;
  logic bwr_n = 1'b1;
  logic [3:0] lane_n = 4'hf;
  logic oe_n = 1'b1;
  logic [19:0] addr = '0;
  logic [31:0] din = '0;
  logic stall = 1'b0;
  logic [31:0] dq_out, rd_data;
  logic [19:0] burst_addr;
  logic dq_oe, cmd_valid, cmd_ready, rd_valid, sleeping, acc_ready;
  sbsc_pkg::sbsc_cmd_t cmd;
  sbsc_pkg::sbsc_cycle_t kind;
  sbsc_pkg::sbsc_cmd_t log_q[$];
  int err_count = 0;
  int n_tests = 0;
  int cycles = 0;

  sbsc_cycle_ctrl sbsc_cycle_ctrl_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .burst_order(order), .sleep_request(sleep), .chip_select_first_n(sel1_n),
    .chip_select_second(sel2), .chip_select_third_n(sel3_n),
    .processor_addr_strobe_n(pstb_n), .controller_addr_strobe_n(cstb_n),
    .burst_advance_n(step_n), .global_write_n(glw_n), .byte_write_enable_n(bwr_n),
    .byte_lane_select_n(lane_n), .output_enable_n(oe_n), .addr_in(addr), .dq_in(din),
    .dq_out(dq_out), .dq_oe(dq_oe), .arr_cmd_valid(cmd_valid), .arr_cmd_ready(cmd_ready),
    .arr_cmd(cmd), .arr_rd_valid(rd_valid), .arr_rd_data(rd_data), .cycle_kind(kind),
    .burst_addr(burst_addr), .sleeping(sleeping), .cmd_accept_ready(acc_ready));

  sbsc_array_model sbsc_array_model_inst (.sys_clk(sys_clk), .rst_n(rst_n), .stall(stall),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .rd_valid(rd_valid),
    .rd_data(rd_data));

  // ---------------------------------------------------------------
  // Clock, command log and hang guard
  // ---------------------------------------------------------------
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Log every command the array accepts, in order
  always @(posedge sys_clk) begin
    if (cmd_valid === 1'b1 && cmd_ready) log_q.push_back(cmd);
  end

  // The whole run needs well under 3000 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      conclude();
    end
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic conclude();
    if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk

  // Inputs change 2 ns after the edge, so each call is one bus cycle
  task automatic drv(input logic [5:0] ctl, input logic [3:0] ln, input logic [19:0] a,
                     input logic [31:0] d);
    {sel1_n, pstb_n, cstb_n, step_n, glw_n, bwr_n} = ctl;
    lane_n = ln;
    addr = a;
    din = d;
    @(posedge sys_clk);
    #2;
  endtask : drv

  task automatic wait_log(input int n);
    for (int i = 0; i < 60 && log_q.size() < n; i++) drv(IDL, 4'hf, '0, '0);
    chk(log_q.size(), n, "command count");
  endtask : wait_log

  task automatic chk_cmd(input int i, input logic [19:0] a, input logic w);
    chk({log_q[i].addr, log_q[i].write}, {a, w}, "command address and kind");
  endtask : chk_cmd

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_burst(input logic ord, input logic [1:0] base);
    logic [1:0] b;
    order = ord;
    oe_n = 1'b0;
    log_q.delete();
    // write inputs and controller strobe ignored
    drv(PST, 4'h0, {18'h2d2c5, base}, '0);
    chk(kind, sbsc_pkg::SBSC_BEGIN_RD, "cycle kind");
    chk(dq_oe, 1'b1, "data drive");
    oe_n = 1'b1;
    #1;
    chk(dq_oe, 1'b0, "data drive");
    order = ~ord; // Order is taken at start only
    for (int j = 0; j < 4; j++) begin
      drv(CNT, 4'hf, '0, '0);
      chk(kind, sbsc_pkg::SBSC_CONT, "cycle kind");
      b = ord ? base ^ 2'(j + 1) : 2'(base + j + 1);
      chk(burst_addr, {18'h2d2c5, b}, "burst address");
    end
    wait_log(5);
    for (int k = 0; k < 5; k++) begin
      b = ord ? base ^ k[1:0] : base + k[1:0];
      chk_cmd(k, {18'h2d2c5, b}, 1'b0);
    end
  endtask : t_burst

  task automatic t_write();
    log_q.delete();
    order = 1'b0;
    // output enable raised before the write
    oe_n = 1'b1;
    drv(CSG, 4'hf, A2, 32'h11223344);
    chk(kind, sbsc_pkg::SBSC_BEGIN_WR, "cycle kind");
    oe_n = 1'b0;
    drv(SUB, 4'hd, '0, 32'haabbccdd);
    chk(kind, sbsc_pkg::SBSC_SUSP, "cycle kind");
    chk(dq_oe, 1'b0, "data drive in write");
    drv(SUR, 4'hf, '0, '0);
    chk(kind, sbsc_pkg::SBSC_SUSP, "cycle kind");
    drv(CNT, 4'hf, '0, '0);
    drv(CSB, 4'hf, A2, '0);
    wait_log(5);
    chk_cmd(0, A2, 1'b1);
    chk(log_q[0].lane_n, 4'h0, "global write lanes");
    chk(log_q[0].data, 32'h11223344, "write data");
    chk_cmd(1, A2, 1'b1);
    chk(log_q[1].lane_n, 4'hd, "byte write lanes");
    chk(log_q[1].data, 32'haabbccdd, "write data");
    chk_cmd(2, A2, 1'b0);
    chk_cmd(3, A2 + 20'h1, 1'b0);
    chk_cmd(4, A2, 1'b0);
    repeat (3) drv(IDL, 4'hf, '0, '0);
    chk(dq_out, 32'h1122cc44, "read data");
  endtask : t_write

  task automatic t_desel();
    log_q.delete();
    drv(IDL, 4'hf, '0, '0);
    sel2 = 1'b0;
    drv(PST, 4'hf, A2, '0);
    chk(kind, sbsc_pkg::SBSC_DESEL, "cycle kind");
    sel2 = 1'b1;
    sel3_n = 1'b1;
    drv(CSG, 4'hf, A2, '0);
    chk(kind, sbsc_pkg::SBSC_DESEL, "cycle kind");
    sel3_n = 1'b0;
    // Deselect ended the burst, so a continue write finds nothing to do
    drv(CNW, 4'hf, '0, '0);
    chk(kind, sbsc_pkg::SBSC_IDLE, "cycle kind");
    repeat (4) drv(IDL, 4'hf, '0, '0);
    chk(log_q.size(), 0, "commands after deselect");
  endtask : t_desel

  task automatic t_full();
    int taken;
    logic full_seen;
    logic idle_seen;
    taken = 1; // The opening read is queued as well
    full_seen = 1'b0;
    idle_seen = 1'b0;
    log_q.delete();
    stall = 1'b1;
    drv(PST, 4'hf, A2, '0);
    for (int i = 0; i < 45; i++) begin
      drv(i < 44 ? SUR : IDL, 4'hf, '0, '0);
      if (kind === sbsc_pkg::SBSC_SUSP || kind === sbsc_pkg::SBSC_BEGIN_RD) taken++;
      if (kind === sbsc_pkg::SBSC_IDLE) idle_seen = 1'b1;
      if (acc_ready === 1'b0) full_seen = 1'b1;
    end
    stall = 1'b0;
    chk({full_seen, idle_seen}, 2'h3, "queue refusal");
    chk(taken >= `SBSC_FIFO_DEPTH, 1'b1, "queued commands");
    wait_log(taken);
    repeat (3) drv(IDL, 4'hf, '0, '0);
    chk(log_q.size(), taken, "drained commands");
  endtask : t_full

  task automatic t_sleep();
    int n;
    drv(IDL, 4'hf, '0, '0);
    log_q.delete();
    sleep = 1'b1;
    n = 0;
    while (sleeping !== 1'b1 && n < 10) begin
      drv(IDL, 4'hf, '0, '0);
      n++;
    end
    chk(n >= 2 && n <= 6, 1'b1, "sleep entry cycles");
    oe_n = 1'b0;
    drv(PST, 4'hf, A2, '0);
    drv(IDL, 4'hf, '0, '0);
    chk(kind, sbsc_pkg::SBSC_SLEEP, "cycle kind");
    chk(dq_oe, 1'b0, "data drive asleep");
    chk(log_q.size(), 0, "commands asleep");
    sleep = 1'b0;
    n = 0;
    // both strobes stay high from the release onward
    while (sleeping !== 1'b0 && n < 10) begin
      drv(SUR, 4'hf, '0, '0);
      n++;
    end
    chk(n >= 2 && n <= 6, 1'b1, "sleep exit cycles");
    // recovery with selects and strobes idle
    repeat (2) drv(SUR, 4'hf, '0, '0);
    drv(PST, 4'hf, A2, '0);
    wait_log(1);
    repeat (3) drv(IDL, 4'hf, '0, '0);
    chk(dq_out, 32'h1122cc44, "data after sleep");
  endtask : t_sleep

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge sys_clk);
    #2;
    chk({kind, sleeping, acc_ready, dq_oe, cmd_valid}, {sbsc_pkg::SBSC_IDLE, 4'h4}, "reset");
    rst_n = 1'b1;
    drv(IDL, 4'hf, '0, '0);
    for (int o = 0; o < 2; o++) begin
      for (int b = 0; b < 4; b++) t_burst(o[0], b[1:0]);
    end
    t_write();
    t_desel();
    t_full();
    t_sleep();
    conclude();
  end
endmodule : tb
